//--- design/qerm_pkg.sv
// qerm_pkg: constants and carriers for the quadword check-code path
// assumes a single memory-controller clock domain
package qerm_pkg;

    // ****************************************
    // sizes and codes
    // ****************************************
    localparam int unsigned QW_BITS   = 64;
    localparam int unsigned CHK_BITS  = 8;
    localparam int unsigned BE_BITS   = 8;
    localparam int unsigned ADDR_BITS = 29;

    localparam logic [7:0] BE_FULL = 8'hFF;

    typedef enum logic [2:0] {
        QERM_IDLE  = 3'b000,
        QERM_RD    = 3'b001,
        QERM_RWAIT = 3'b010,
        QERM_MRD   = 3'b011,
        QERM_MWAIT = 3'b100,
        QERM_WR    = 3'b101,
        QERM_RESP  = 3'b110
    } qerm_state_e;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic                 we;
        logic [ADDR_BITS-1:0] addr;
        logic [BE_BITS-1:0]   be;
        logic [QW_BITS-1:0]   data;
    } qerm_req_s;

    typedef struct packed {
        logic                 we;
        logic [ADDR_BITS-1:0] addr;
        logic [QW_BITS-1:0]   data;
        logic [CHK_BITS-1:0]  chk;
    } qerm_mem_cmd_s;

    typedef struct packed {
        logic [QW_BITS-1:0]  data;
        logic [CHK_BITS-1:0] chk;
    } qerm_mem_rd_s;

    typedef struct packed {
        logic [QW_BITS-1:0] data;
        logic               data_ok;
        logic               corrected;
        logic               uncorrectable;
    } qerm_rsp_s;

endpackage : qerm_pkg

//--- design/qerm_top.sv
// qerm_top: check-code generation, read-merge-write and correction
// assumes requester and memory side both on mclk_i, one request at a time
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - with checking on, an 8-bit code is computed for each 64-bit quadword stored
// R2 - with checking on, every memory write is a whole quadword plus its code
// R3 - partial writes: read quadword, merge bytes, recode, write whole quadword back (with checking off the code writes the request data unmerged)
// R4 - a single-bit error in the merge read is corrected before merging
// R5 - reads correct any single-bit error and detect any two-bit error
// R6 - checking is a static option; without it no code is made or checked
// R7 - uncorrectable errors raise a visible flag and the data is not marked valid (the code writes back a merge over an uncorrectable read with a fresh code)
module qerm_top
    import qerm_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ecc_en_i,
    input  wire logic          req_valid_i,
    output logic               req_ready_o,
    input  wire qerm_req_s     req_i,
    output logic               rsp_valid_o,
    output qerm_rsp_s          rsp_o,
    output logic               mem_valid_o,
    input  wire logic          mem_ready_i,
    output qerm_mem_cmd_s      mem_cmd_o,
    input  wire logic          mem_rd_valid_i,
    input  wire qerm_mem_rd_s  mem_rd_i,
    output logic               ue_flag_o,
    output logic               ce_flag_o
);

    // ****************************************
    // code functions (extended Hamming 72,64)
    // ****************************************
    // position of data bit d in the 71-bit Hamming word (non powers of two)
    function automatic logic [6:0] qerm_pos(input int unsigned d);
        int unsigned p;
        int unsigned k;
        p = 0;
        k = 0;
        for (int unsigned i = 1; i < 72; i++) begin
            if ((i & (i - 1)) != 0) begin
                if (k == d) begin
                    p = i;
                end
                k++;
            end
        end
        return p[6:0];
    endfunction : qerm_pos

    function automatic logic [CHK_BITS-1:0] qerm_code(input logic [QW_BITS-1:0] d);
        logic [6:0] s;
        logic       par;
        s = 7'h00;
        par = 1'b0;
        for (int unsigned i = 0; i < QW_BITS; i++) begin
            if (d[i]) begin
                s = s ^ qerm_pos(i);
            end
        end
        par = ^d ^ ^s;
        return {par, s};
    endfunction : qerm_code

    // returns corrected data, single flag, double flag
    function automatic logic [QW_BITS+1:0] qerm_fix(input logic [QW_BITS-1:0] d,
                                                    input logic [CHK_BITS-1:0] c);
        logic [CHK_BITS-1:0] x;
        logic [CHK_BITS-1:0] g;
        logic [QW_BITS-1:0]  o;
        logic                sgl;
        logic                dbl;
        g = qerm_code(d);
        // parity over all 72 received bits, syndrome over the seven code bits
        x = {^{d, c}, g[6:0] ^ c[6:0]};
        o = d;
        sgl = 1'b0;
        dbl = 1'b0;
        if (x != 8'h00) begin
            if (x[7]) begin
                sgl = 1'b1;
                for (int unsigned i = 0; i < QW_BITS; i++) begin
                    if (qerm_pos(i) == x[6:0]) begin
                        o[i] = ~o[i];
                    end
                end
            end else begin
                dbl = 1'b1;
            end
        end
        return {o, sgl, dbl};
    endfunction : qerm_fix

    function automatic logic [QW_BITS-1:0] qerm_merge(input logic [QW_BITS-1:0] old,
                                                      input logic [QW_BITS-1:0] nw,
                                                      input logic [BE_BITS-1:0] be);
        logic [QW_BITS-1:0] m;
        m = old;
        for (int unsigned b = 0; b < BE_BITS; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return m;
    endfunction : qerm_merge

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        qerm_state_e          st;
        logic                 ecc;
        logic [BE_BITS-1:0]   be;
        logic [QW_BITS-1:0]   wdata;
        qerm_mem_cmd_s        cmd;
        qerm_rsp_s            rsp;
        logic                 ue;
        logic                 ce;
    } qerm_state_s;

    qerm_state_s r;
    qerm_state_s next_r;
    logic [QW_BITS+1:0] fix;

    always_comb begin
        fix = qerm_fix(mem_rd_i.data, mem_rd_i.chk);
        next_r = r;
        unique case (r.st)
            QERM_IDLE: begin
                // R6 option latched only while idle
                next_r.ecc = ecc_en_i;
                if (req_valid_i) begin
                    next_r.be = req_i.be;
                    next_r.wdata = req_i.data;
                    next_r.cmd.addr = req_i.addr;
                    next_r.cmd.data = req_i.data;
                    // R1 code computed for every request while checking is on, zero when off
                    next_r.cmd.chk = ecc_en_i ? qerm_code(req_i.data) : 8'h00;
                    if (!req_i.we) begin
                        next_r.cmd.we = 1'b0;
                        next_r.st = QERM_RD;
                    end else if (ecc_en_i && req_i.be != BE_FULL) begin
                        // R3 partial write starts with a read
                        next_r.cmd.we = 1'b0;
                        next_r.st = QERM_MRD;
                    end else begin
                        next_r.cmd.we = 1'b1;
                        next_r.st = QERM_WR;
                    end
                end
            end
            QERM_RD: begin
                if (mem_ready_i) begin
                    next_r.st = QERM_RWAIT;
                end
            end
            QERM_RWAIT: begin
                if (mem_rd_valid_i) begin
                    next_r.st = QERM_RESP;
                    next_r.rsp.corrected = 1'b0;
                    next_r.rsp.uncorrectable = 1'b0;
                    next_r.rsp.data_ok = 1'b1;
                    next_r.rsp.data = mem_rd_i.data;
                    if (r.ecc) begin
                        // R5 correct single, detect double
                        next_r.rsp.data = fix[QW_BITS+1:2];
                        next_r.rsp.corrected = fix[1];
                        next_r.rsp.uncorrectable = fix[0];
                        // R7 bad data never marked valid
                        next_r.rsp.data_ok = ~fix[0];
                        next_r.ue = r.ue | fix[0];
                        next_r.ce = r.ce | fix[1];
                    end
                end
            end
            QERM_MRD: begin
                if (mem_ready_i) begin
                    next_r.st = QERM_MWAIT;
                end
            end
            QERM_MWAIT: begin
                if (mem_rd_valid_i) begin
                    // R4 merge onto the corrected quadword
                    next_r.cmd.data = qerm_merge(fix[QW_BITS+1:2], r.wdata, r.be);
                    // R2 whole quadword with fresh code
                    next_r.cmd.chk = qerm_code(qerm_merge(fix[QW_BITS+1:2], r.wdata, r.be));
                    next_r.cmd.we = 1'b1;
                    next_r.ce = r.ce | fix[1];
                    next_r.ue = r.ue | fix[0];
                    next_r.rsp.corrected = fix[1];
                    next_r.rsp.uncorrectable = fix[0];
                    next_r.rsp.data_ok = ~fix[0];
                    next_r.rsp.data = 64'h0000000000000000;
                    next_r.st = QERM_WR;
                end
            end
            QERM_WR: begin
                if (mem_ready_i) begin
                    if (r.be == BE_FULL || !r.ecc) begin
                        next_r.rsp.corrected = 1'b0;
                        next_r.rsp.uncorrectable = 1'b0;
                        next_r.rsp.data_ok = 1'b1;
                        next_r.rsp.data = 64'h0000000000000000;
                    end
                    next_r.st = QERM_RESP;
                end
            end
            QERM_RESP: begin
                next_r.st = QERM_IDLE;
            end
            default: begin
                next_r.st = QERM_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign req_ready_o = (r.st == QERM_IDLE);
    assign mem_valid_o = (r.st == QERM_RD) || (r.st == QERM_MRD) || (r.st == QERM_WR);
    assign mem_cmd_o   = r.cmd;
    assign rsp_valid_o = (r.st == QERM_RESP);
    assign rsp_o       = r.rsp;
    assign ue_flag_o   = r.ue;
    assign ce_flag_o   = r.ce;

    // ****************************************
    // assertions
    // ****************************************
    property p_full_write;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (mem_valid_o && mem_cmd_o.we && r.ecc) |-> (mem_cmd_o.chk == qerm_code(mem_cmd_o.data));
    endproperty
    a_full_write: assert property (p_full_write) else $error("write code mismatch"); // R2

    property p_code_width;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (req_valid_i && req_ready_o && req_i.we && ecc_en_i && req_i.be == BE_FULL)
        |=> (mem_cmd_o.chk == qerm_code($past(req_i.data)));
    endproperty
    a_code_width: assert property (p_code_width) else $error("code not computed"); // R1

    property p_rmw_order;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (req_valid_i && req_ready_o && req_i.we && ecc_en_i && req_i.be != BE_FULL)
        |=> (mem_valid_o && !mem_cmd_o.we);
    endproperty
    a_rmw_order: assert property (p_rmw_order) else $error("partial write did not read first"); // R3

    property p_merge_fix;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (r.st == QERM_MWAIT && mem_rd_valid_i && fix[1])
        |=> (mem_cmd_o.data == qerm_merge($past(fix[QW_BITS+1:2]), r.wdata, r.be));
    endproperty
    a_merge_fix: assert property (p_merge_fix) else $error("merge used uncorrected data"); // R4

    property p_read_fix;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (r.st == QERM_RWAIT && mem_rd_valid_i && r.ecc)
        |=> rsp_valid_o && rsp_o.uncorrectable == $past(fix[0]) && rsp_o.corrected == $past(fix[1]);
    endproperty
    a_read_fix: assert property (p_read_fix) else $error("read check wrong"); // R5

    property p_no_ecc;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (mem_valid_o && mem_cmd_o.we && !r.ecc) |-> (mem_cmd_o.chk == 8'h00);
    endproperty
    a_no_ecc: assert property (p_no_ecc) else $error("code made with checking off"); // R6

    property p_ue_flag;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (rsp_valid_o && rsp_o.uncorrectable) |-> (ue_flag_o && !rsp_o.data_ok);
    endproperty
    a_ue_flag: assert property (p_ue_flag) else $error("bad data marked valid"); // R7

    property p_ue_sticky;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ue_flag_o |=> ue_flag_o;
    endproperty
    a_ue_sticky: assert property (p_ue_sticky) else $error("error flag dropped"); // R7

    c_read:  cover property (@(posedge mclk_i) disable iff (!rst_n_i) rsp_valid_o && rsp_o.corrected);
    c_rmw:   cover property (@(posedge mclk_i) disable iff (!rst_n_i) r.st == QERM_MWAIT ##1 r.st == QERM_WR);
    c_ue:    cover property (@(posedge mclk_i) disable iff (!rst_n_i) rsp_valid_o && rsp_o.uncorrectable);

endmodule : qerm_top

`default_nettype wire

//--- verification/qerm_mem_model.sv
// qerm_mem_model: 16 quadwords with their codes, picked by the low address bits
// assumes the qerm_top memory port on the same clock; flip_i corrupts read returns
`timescale 1ns/1ps
`default_nettype none
module qerm_mem_model
    import qerm_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          slow_i,
    input  wire logic [71:0]   flip_i,
    input  wire logic          mem_valid_i,
    output logic               mem_ready_o,
    input  wire qerm_mem_cmd_s mem_cmd_i,
    output logic               mem_rd_valid_o,
    output qerm_mem_rd_s       mem_rd_o,
    output qerm_mem_cmd_s      last_wr_o
);
    qerm_mem_rd_s         store [0:15];
    logic [ADDR_BITS-1:0] ra;
    logic [2:0]           wcnt;
    logic [2:0]           rcnt;
    logic                 pend;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_ready_o    <= 1'b0;
            mem_rd_valid_o <= 1'b0;
            mem_rd_o       <= '0;
            last_wr_o      <= '0;
            ra             <= '0;
            wcnt           <= '0;
            rcnt           <= '0;
            pend           <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                store[i] <= '0;
            end
        end else begin
            mem_ready_o    <= 1'b0;
            mem_rd_valid_o <= 1'b0;
            // idle read bus keeps changing
            mem_rd_o       <= ~mem_rd_o;
            wcnt           <= '0;
            if (mem_valid_i && mem_ready_o) begin
                if (mem_cmd_i.we) begin
                    store[mem_cmd_i.addr[3:0]] <= {mem_cmd_i.data, mem_cmd_i.chk};
                    last_wr_o             <= mem_cmd_i;
                end else begin
                    pend <= 1'b1;
                    ra   <= mem_cmd_i.addr;
                    rcnt <= slow_i ? 3'd4 : 3'd0;
                end
            end else if (mem_valid_i && !pend) begin
                wcnt        <= wcnt + 3'd1;
                mem_ready_o <= (wcnt >= (slow_i ? 3'd3 : 3'd0));
            end
            if (pend) begin
                rcnt <= rcnt - 3'd1;
                if (rcnt == 3'd0) begin
                    pend           <= 1'b0;
                    mem_rd_valid_o <= 1'b1;
                    mem_rd_o       <= store[ra[3:0]] ^ flip_i;
                end
            end
        end
    end
endmodule : qerm_mem_model
`default_nettype wire

//--- verification/qerm_top_test.sv
// qerm_top_test: scenario testbench for qerm_top
// assumes qerm_mem_model as the memory; one request at a time
`timescale 1ns/1ps
`default_nettype none
module qerm_top_test
    import qerm_pkg::*;
;
    localparam logic [ADDR_BITS-1:0] ADR = 29'h0ABC_DEF;
    logic          mclk, rst_n, ecc_en, req_valid, req_ready, rsp_valid, slow;
    logic          mem_valid, mem_ready, mem_rd_valid, ue_flag, ce_flag;
    logic [71:0]   flip;
    logic [63:0]   cur;
    qerm_req_s     req;
    qerm_rsp_s     rsp;
    qerm_rsp_s     got;
    qerm_mem_cmd_s mem_cmd;
    qerm_mem_cmd_s last_wr;
    qerm_mem_rd_s  mem_rd;
    int            n_mismatch = 0;
    int            checked = 0;

    qerm_top u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .ecc_en_i(ecc_en), .req_valid_i(req_valid),
        .req_ready_o(req_ready), .req_i(req), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
        .mem_valid_o(mem_valid), .mem_ready_i(mem_ready), .mem_cmd_o(mem_cmd),
        .mem_rd_valid_i(mem_rd_valid), .mem_rd_i(mem_rd), .ue_flag_o(ue_flag), .ce_flag_o(ce_flag));
    qerm_mem_model u_mem (.clk_i(mclk), .rst_n_i(rst_n), .slow_i(slow), .flip_i(flip),
        .mem_valid_i(mem_valid), .mem_ready_o(mem_ready), .mem_cmd_i(mem_cmd),
        .mem_rd_valid_o(mem_rd_valid), .mem_rd_o(mem_rd), .last_wr_o(last_wr));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] ecc_of(input logic [63:0] d);
        logic [6:0] s;
        int         p;
        s = '0;
        p = 0;
        for (int i = 0; i < 64; i++) begin
            p++;
            while ((p & (p - 1)) == 0) p++;
            if (d[i]) s ^= p[6:0];
        end
        return {^{d, s}, s};
    endfunction : ecc_of

    function automatic logic [63:0] mrg(input logic [63:0] o, input logic [63:0] n, input logic [7:0] be);
        for (int i = 0; i < 8; i++) if (be[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction : mrg

    task automatic cmp_data(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_data

    task automatic cmp_flag(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_flag

    task automatic cmp_chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_chk

    task automatic do_req(input logic we, input logic [7:0] be, input logic [63:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req       <= {we, ADR, be, d};
        @(posedge mclk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        req_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        got = rsp;
        cmp_flag(rsp_valid, 1'b1);
    endtask : do_req

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_full;
        slow <= 1'b1;
        cur = 64'h0123_4567_89AB_CDEF;
        do_req(1'b1, BE_FULL, cur);
        cmp_data(last_wr.data, cur);
        cmp_chk(last_wr.chk, ecc_of(cur));
        cmp_data(got.data, '0);
        do_req(1'b0, 8'h00, '0);
        cmp_data(got.data, cur);
        cmp_flag(got.data_ok, 1'b1);
        slow <= 1'b0;
    endtask : t_full

    task automatic t_partial;
        logic [7:0]  bes [3];
        logic [63:0] n;
        bes = '{8'h01, 8'h80, 8'h3C};
        n = 64'hFEDC_BA98_7654_3210;
        foreach (bes[i]) begin
            n = ~n;
            do_req(1'b1, bes[i], n);
            cur = mrg(cur, n, bes[i]);
            cmp_data(last_wr.data, cur);
            cmp_chk(last_wr.chk, ecc_of(cur));
        end
    endtask : t_partial

    task automatic t_merge_fix;
        cmp_flag(ce_flag, 1'b0);
        flip <= 72'h1 << 50;
        do_req(1'b1, 8'h0F, '0);
        flip <= '0;
        cur = mrg(cur, '0, 8'h0F);
        cmp_data(last_wr.data, cur);
        cmp_flag(got.corrected, 1'b1);
        cmp_flag(ce_flag, 1'b1);
    endtask : t_merge_fix

    task automatic t_read_err;
        for (int k = 0; k < 72; k++) begin
            flip <= 72'h1 << k;
            do_req(1'b0, 8'h00, '0);
            cmp_data(got.data, cur);
            cmp_flag(got.corrected, 1'b1);
        end
        for (int k = 0; k < 71; k += 7) begin
            flip <= 72'h3 << k;
            do_req(1'b0, 8'h00, '0);
            cmp_flag(got.uncorrectable, 1'b1);
            cmp_flag(got.data_ok, 1'b0);
        end
        flip <= '0;
        do_req(1'b0, 8'h00, '0);
        cmp_flag(got.uncorrectable, 1'b0);
        cmp_flag(ue_flag, 1'b1);
    endtask : t_read_err

    task automatic t_off;
        ecc_en <= 1'b0;
        do_req(1'b1, BE_FULL, ~cur);
        cmp_chk(last_wr.chk, 8'h00);
        flip <= 72'h1 << 8;
        do_req(1'b0, 8'h00, '0);
        flip <= '0;
        cmp_data(got.data, ~cur ^ 64'h1);
        cmp_flag(got.corrected, 1'b0);
        // partial write with checking off goes straight out as a whole quadword
        do_req(1'b1, 8'h0F, cur);
        cmp_data(last_wr.data, cur);
        cmp_chk(last_wr.chk, 8'h00);
    endtask : t_off

    task automatic end_of_test;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        rst_n = 1'b0;
        ecc_en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        flip = '0;
        repeat (16) @(posedge mclk);
        cmp_flag(req_ready, 1'b1);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_full();
        t_partial();
        t_merge_fix();
        t_read_err();
        t_off();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        end_of_test();
    end
endmodule : qerm_top_test
`default_nettype wire
